// File: annps_status_regs.sv
// Read-only auto-negotiation next-page and expansion status registers.
//
// Contract
// - Bit 15 of the next-page register reads 1 when the partner wants another page.
// - Bit 14 of the next-page register shows the partner acknowledge taken from pulse bursts.
// - Bit 13 of the next-page register shows message page (1) or unformatted page (0), reset 0.
// - Bit 12 of the next-page register reads 1 when the partner can comply, reset 0.
// - Bit 11 of the next-page register holds the toggle value of the partner page, reset 0.
// - Bits 10 to 0 of the next-page register hold the partner's 11-bit code, reset 0.
// - Bits 15 to 5 of the expansion register ignore writes and read as zero.
// - Bit 4 of the expansion register reads 1 on a parallel detection fault, reset 0.
// - Bit 3 of the expansion register reads 1 when the partner supports next pages, reset 0.
// - Bit 2 of the expansion register is a constant 1 showing local next-page ability.
// - Bit 1 of the expansion register sets on a received page and clears on a read.
// - Bit 0 of the expansion register reads 1 when the partner supports negotiation, reset 0.
`timescale 1ns/10ps
`default_nettype none
module annps_status_regs (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_rd,
  input  wire logic [4:0]               i_addr,
  input  wire logic                     i_page_valid,
  input  wire annps_pkg::annps_page_s   i_page,
  input  wire annps_pkg::annps_status_s i_status,
  output logic [15:0]                   o_rdata,
  output logic                          o_rvalid
);

  logic                    exp_rd;
  logic                    page_rx;
  annps_pkg::annps_page_s  page_q;
  annps_pkg::annps_status_s status_r;
  logic [15:0]             exp_word;
  logic [15:0]             rdata_nxt;
  logic                    pg_rd;

  // A read of the expansion register is what clears the received flag.
  // Only a read of that one address clears it, so polling the page word is harmless.
  assign exp_rd = i_rd && (i_addr == annps_pkg::ADDR_AUTONEG_EXPANSION_STATUS);

  // A read of the received page word; used only by the checks below.
  assign pg_rd = i_rd && (i_addr == annps_pkg::ADDR_PARTNER_NEXT_PAGE_ABILITY);

  // The page word and the flag live in small helper blocks of their own.
  // Both are loaded by the same one-cycle strobe, so the flag can never
  // announce a page that the holding register has not yet taken.

  annps_page_capture u_capture (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_load (i_page_valid),
    .i_page (i_page),
    .o_page (page_q)
  );

  annps_page_rx_flag u_flag (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_set   (i_page_valid),
    .i_clear (exp_rd),
    .o_flag  (page_rx)
  );

  // Status levels come from negotiation logic on this clock, so one register stage suffices.
  // The stage costs a cycle of latency, which software polling over a slow bus never notices.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_r <= '0;
    end else begin
      status_r <= i_status;
    end
  end

  // Expansion word; upper bits are constant zero, so writes have nothing to land on.
  // The local page ability bit is taken from the reset image so both agree by construction.
  always_comb begin
    exp_word = annps_pkg::READ_ZERO;
    exp_word[annps_pkg::EXP_FAULT_BIT]         = status_r.parallel_detect_fault;
    exp_word[annps_pkg::EXP_PARTNER_PAGES_BIT] = status_r.partner_supports_extra_pages;
    exp_word[annps_pkg::EXP_LOCAL_PAGES_BIT]   =
      annps_pkg::EXPANSION_RESET[annps_pkg::EXP_LOCAL_PAGES_BIT];
    exp_word[annps_pkg::EXP_PAGE_RX_BIT]  = page_rx;
    exp_word[annps_pkg::EXP_LP_AN_BIT]    = status_r.partner_negotiation_capable;
  end

  // Read multiplexer; the flag value before clearing is what the read returns.
  always_comb begin
    if (i_addr == annps_pkg::ADDR_PARTNER_NEXT_PAGE_ABILITY) begin
      rdata_nxt = page_q;
    end else if (i_addr == annps_pkg::ADDR_AUTONEG_EXPANSION_STATUS) begin
      rdata_nxt = exp_word;
    end else begin
      rdata_nxt = annps_pkg::READ_ZERO;
    end
  end

  // Read data is registered and held until the next read.
  // Holding it lets a slow serial master shift it out without a second strobe.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata  <= annps_pkg::READ_ZERO;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= rdata_nxt;
      end
    end
  end

  property p_upper_zero;
    @(posedge i_clk) disable iff (i_rst) exp_rd |=> (o_rdata[15:5] == 11'h000);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("expansion upper bits not zero");

  property p_local_pages;
    @(posedge i_clk) disable iff (i_rst) exp_rd |=> o_rdata[2];
  endproperty
  a_local_pages: assert property (p_local_pages) else $error("local page bit not one");

  property p_read_clears;
    @(posedge i_clk) disable iff (i_rst) (exp_rd && page_rx && !i_page_valid) ##1 exp_rd
      |=> (o_rdata[1] == 1'b0);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("second read saw flag");

  property p_fault;
    @(posedge i_clk) disable iff (i_rst)
      exp_rd |=> (o_rdata[4] == $past(status_r.parallel_detect_fault));
  endproperty
  a_fault: assert property (p_fault) else $error("fault bit wrong");

  property p_lpnp;
    @(posedge i_clk) disable iff (i_rst) exp_rd |=> (o_rdata[3] == $past(status_r.partner_supports_extra_pages));
  endproperty
  a_lpnp: assert property (p_lpnp) else $error("partner page bit wrong");

  property p_lpan;
    @(posedge i_clk) disable iff (i_rst) exp_rd |=> (o_rdata[0] == $past(status_r.partner_negotiation_capable));
  endproperty
  a_lpan: assert property (p_lpan) else $error("partner negotiation bit wrong");

  property p_page_read;
    @(posedge i_clk) disable iff (i_rst)
      i_page_valid ##1 (i_rd && !i_page_valid && i_addr == annps_pkg::ADDR_PARTNER_NEXT_PAGE_ABILITY)
      |=> (o_rdata == $past(i_page, 2));
  endproperty
  a_page_read: assert property (p_page_read) else $error("page read mismatch");

  property p_rvalid;
    @(posedge i_clk) disable iff (i_rst) i_rd |=> o_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");

  // Field checks of the page word. Each field is looked at on its own so a
  // swapped pair of bits shows up by name rather than as one bad word.
  // They compare against the held word, which a page strobe may replace in
  // the very cycle of the read; the read returns the word before that.

  // The further page request sits at the top of the word.
  property p_further_page;
    @(posedge i_clk) disable iff (i_rst)
      pg_rd |=> (o_rdata[annps_pkg::PG_FURTHER_PAGE_BIT] == $past(page_q.further_page_request));
  endproperty
  a_further_page: assert property (p_further_page) else $error("further page bit wrong");

  // The acknowledge bit comes straight from the received word.
  property p_ack_bit;
    @(posedge i_clk) disable iff (i_rst)
      pg_rd |=> (o_rdata[annps_pkg::PG_ACK_BIT] == $past(page_q.ack));
  endproperty
  a_ack_bit: assert property (p_ack_bit) else $error("acknowledge bit wrong");

  // Message or unformatted page type.
  property p_message_page;
    @(posedge i_clk) disable iff (i_rst)
      pg_rd |=> (o_rdata[annps_pkg::PG_MESSAGE_PAGE_BIT] == $past(page_q.message_page_flag));
  endproperty
  a_message_page: assert property (p_message_page) else $error("page type bit wrong");

  // Ability of the partner to comply with the message.
  property p_comply;
    @(posedge i_clk) disable iff (i_rst)
      pg_rd |=> (o_rdata[annps_pkg::PG_COMPLY_BIT] == $past(page_q.partner_can_comply));
  endproperty
  a_comply: assert property (p_comply) else $error("comply bit wrong");

  // Toggle bit of the received word.
  property p_toggle;
    @(posedge i_clk) disable iff (i_rst)
      pg_rd |=> (o_rdata[annps_pkg::PG_TOGGLE_BIT] == $past(page_q.toggle));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle bit wrong");

  // Eleven-bit code field.
  property p_code;
    @(posedge i_clk) disable iff (i_rst)
      pg_rd |=> (o_rdata[annps_pkg::PG_CODE_MSB:0] == $past(page_q.code));
  endproperty
  a_code: assert property (p_code) else $error("code field wrong");

  // The held word only changes on a page strobe.
  property p_page_hold;
    @(posedge i_clk) disable iff (i_rst) !i_page_valid |=> $stable(page_q);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page word changed unasked");

  // Values seen at the first edge after reset is released. The reset is
  // asynchronous, so these state that nothing moved before the clock came.

  // The page word starts out all zero.
  property p_reset_page;
    @(posedge i_clk) disable iff (i_rst) $fell(i_rst) |-> (page_q == annps_pkg::PARTNER_PAGE_RESET);
  endproperty
  a_reset_page: assert property (p_reset_page) else $error("page word not reset");

  // The received flag starts out clear.
  property p_reset_flag;
    @(posedge i_clk) disable iff (i_rst) $fell(i_rst) |-> !page_rx;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("page flag not reset");

  // The status stage starts out clear.
  property p_reset_status;
    @(posedge i_clk) disable iff (i_rst) $fell(i_rst) |-> (status_r == '0);
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("status not reset");

  // The read data starts out zero.
  property p_reset_rdata;
    @(posedge i_clk) disable iff (i_rst) $fell(i_rst) |-> (o_rdata == annps_pkg::READ_ZERO);
  endproperty
  a_reset_rdata: assert property (p_reset_rdata) else $error("read data not reset");

  // No answer is pending out of reset.
  property p_reset_rvalid;
    @(posedge i_clk) disable iff (i_rst) $fell(i_rst) |-> !o_rvalid;
  endproperty
  a_reset_rvalid: assert property (p_reset_rvalid) else $error("answer pending after reset");

  // Read port behaviour. Unmapped addresses answer zero, and the data holds
  // between reads so a slow master can take it at leisure.

  // An address outside the bank reads as zero.
  property p_unmapped;
    @(posedge i_clk) disable iff (i_rst) (i_rd && !pg_rd && !exp_rd) |=> (o_rdata == 16'h0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // Read data stands until the next read.
  property p_rdata_hold;
    @(posedge i_clk) disable iff (i_rst) !i_rd |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // The expansion word keeps its upper bits at zero at all times.
  property p_exp_upper;
    @(posedge i_clk) disable iff (i_rst) exp_word[15:5] == 11'h000;
  endproperty
  a_exp_upper: assert property (p_exp_upper) else $error("expansion upper bits set");

  // The local page ability bit never drops.
  property p_local_const;
    @(posedge i_clk) disable iff (i_rst) exp_word[annps_pkg::EXP_LOCAL_PAGES_BIT];
  endproperty
  a_local_const: assert property (p_local_const) else $error("local ability dropped");

  // Flag behaviour. A set and a clearing read in the same cycle leave the
  // flag set, while the read itself returns the value from before the edge.

  // A page strobe always leaves the flag set.
  property p_flag_set;
    @(posedge i_clk) disable iff (i_rst) i_page_valid |=> page_rx;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set by page");

  // A read returns the flag as it stood before the clearing edge.
  property p_old_flag;
    @(posedge i_clk) disable iff (i_rst) exp_rd |=> (o_rdata[1] == $past(page_rx));
  endproperty
  a_old_flag: assert property (p_old_flag) else $error("read lost flag value");

  // Without a page or a read the flag keeps its value.
  property p_flag_stable;
    @(posedge i_clk) disable iff (i_rst) (!i_page_valid && !exp_rd) |=> $stable(page_rx);
  endproperty
  a_flag_stable: assert property (p_flag_stable) else $error("flag moved unasked");

  // The status stage follows its input one edge later.
  property p_status_stage;
    @(posedge i_clk) disable iff (i_rst) 1'b1 |=> (status_r == $past(i_status));
  endproperty
  a_status_stage: assert property (p_status_stage) else $error("status stage lagging");

endmodule
`default_nettype wire

// File: annps_pkg.sv
// Package with register offsets, field positions and carrier types for the page status bank.
package annps_pkg;

  // Register addresses on the management register port.
  localparam logic [4:0] ADDR_PARTNER_NEXT_PAGE_ABILITY = 5'h05;
  localparam logic [4:0] ADDR_AUTONEG_EXPANSION_STATUS  = 5'h06;

  // Field positions of the received next-page register.
  localparam int PG_FURTHER_PAGE_BIT = 15;
  localparam int PG_ACK_BIT          = 14;
  localparam int PG_MESSAGE_PAGE_BIT = 13;
  localparam int PG_COMPLY_BIT       = 12;
  localparam int PG_TOGGLE_BIT       = 11;
  localparam int PG_CODE_MSB         = 10;

  // Field positions of the expansion register.
  localparam int EXP_FAULT_BIT         = 4;
  localparam int EXP_PARTNER_PAGES_BIT = 3;
  localparam int EXP_LOCAL_PAGES_BIT   = 2;
  localparam int EXP_PAGE_RX_BIT    = 1;
  localparam int EXP_LP_AN_BIT      = 0;

  // Values after reset.
  localparam logic [15:0] PARTNER_PAGE_RESET = 16'h0000;
  localparam logic [15:0] EXPANSION_RESET    = 16'h0004;
  localparam logic [15:0] READ_ZERO          = 16'h0000;

  // Received link code word as handed over by the arbitration logic.
  typedef struct packed {
    logic        further_page_request;
    logic        ack;
    logic        message_page_flag;
    logic        partner_can_comply;
    logic        toggle;
    logic [10:0] code;
  } annps_page_s;

  // Level status coming from the negotiation logic.
  typedef struct packed {
    logic parallel_detect_fault;
    logic partner_supports_extra_pages;
    logic partner_negotiation_capable;
  } annps_status_s;

endpackage

// File: annps_page_rx_flag.sv
// Sticky page-received flag that clears when software reads it.
`timescale 1ns/10ps
`default_nettype none
module annps_page_rx_flag (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);

  // A new page wins over a clearing read in the same cycle so no page is lost.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end

  property p_set_wins;
    @(posedge i_clk) disable iff (i_rst) i_set |=> o_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("page flag lost a set");

  property p_clear_on_read;
    @(posedge i_clk) disable iff (i_rst) (i_clear && !i_set) |=> !o_flag;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("page flag not cleared");

endmodule
`default_nettype wire

// File: annps_page_capture.sv
// Holding register for the latest received link code word.
`timescale 1ns/10ps
`default_nettype none
module annps_page_capture (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_load,
  input  wire annps_pkg::annps_page_s i_page,
  output annps_pkg::annps_page_s  o_page
);

  // The word is only replaced on a complete reception so a read never sees a half page.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_page <= annps_pkg::PARTNER_PAGE_RESET;
    end else if (i_load) begin
      o_page <= i_page;
    end
  end

  property p_load;
    @(posedge i_clk) disable iff (i_rst) i_load |=> (o_page == $past(i_page));
  endproperty
  a_load: assert property (p_load) else $error("page not captured");

endmodule
`default_nettype wire

// File: annps_partner_model.sv
// Behavioural link partner that delivers received pages and status levels.
`timescale 1ns/10ps
`default_nettype none
module annps_partner_model (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_go,
  input  wire logic [15:0]         i_word,
  input  wire logic [2:0]          i_stat,
  output annps_pkg::annps_page_s   o_page,
  output logic                     o_page_valid,
  output annps_pkg::annps_status_s o_status
);
  // A word is shown for one cycle only; between pages the bus flips every cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_page       <= '0;
      o_page_valid <= 1'b0;
      o_status     <= '0;
    end else begin
      o_page       <= i_go ? i_word : ~o_page;
      o_page_valid <= i_go;
      o_status     <= i_stat;
    end
  end
endmodule
`default_nettype wire

// File: autoneg_next_page_status_tb.sv
// Self-checking bench for the page status registers.
`timescale 1ns/10ps
`default_nettype none
module autoneg_next_page_status_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic rd = 1'b0;
  logic [4:0] addr = 5'h00;
  logic go = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [2:0] stat = 3'h0;
  logic pv;
  annps_pkg::annps_page_s pg;
  annps_pkg::annps_status_s st;
  logic [15:0] rdata;
  logic rvalid;
  int mismatches = 0;
  int samples_checked = 0;
  annps_partner_model partner (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_word(word),
    .i_stat(stat), .o_page(pg), .o_page_valid(pv), .o_status(st));
  annps_status_regs uut (.i_clk(i_clk), .i_rst(i_rst), .i_rd(rd), .i_addr(addr),
    .i_page_valid(pv), .i_page(pg), .i_status(st), .o_rdata(rdata), .o_rvalid(rvalid));
  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One read; the answer is registered at the same edge that takes the strobe.
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string name);
    @(posedge i_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    check({name, " valid"}, 16'h0001, {15'h0, rvalid});
    check(name, exp, rdata);
  endtask
  task automatic page(input logic [15:0] w);
    @(posedge i_clk);
    go <= 1'b1;
    word <= w;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // The whole run is well under a thousand cycles.
  initial begin
    #5000;
    mismatches++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    rd_chk(5'h05, 16'h0000, "page reset");
    rd_chk(5'h06, 16'h0004, "expansion reset");
    rd_chk(5'h07, 16'h0000, "unmapped");
    page(16'hb5a5);
    rd_chk(5'h05, 16'hb5a5, "page one");
    rd_chk(5'h06, 16'h0006, "flag set");
    rd_chk(5'h06, 16'h0004, "flag cleared");
    page(16'h4a5a);
    rd_chk(5'h05, 16'h4a5a, "page two");
    rd_chk(5'h06, 16'h0006, "flag again");
    // Each partner status level in turn lands on its own bit.
    for (int k = 0; k < 3; k++) begin
      stat <= 3'h1 << k;
      repeat (3) @(posedge i_clk);
      rd_chk(5'h06, {11'h0, stat[2], stat[1], 2'b10, stat[0]}, "status");
    end
    stat <= 3'h0;
    // A page arrives at the very edge that takes a clearing read.
    @(posedge i_clk);
    go <= 1'b1;
    word <= 16'h2001;
    @(posedge i_clk);
    go <= 1'b0;
    rd <= 1'b1;
    addr <= 5'h06;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    check("old flag", 16'h0004, rdata);
    rd_chk(5'h06, 16'h0006, "set wins");
    rd_chk(5'h05, 16'h2001, "page three");
    summarize();
  end
endmodule
`default_nettype wire
